// file: core/fpp_pipe.sv
// four-phase fetch/execute pipeline control with accumulator datapath
// assumes program memory answers within the fetch phase and data
// memory takes the registered write one phase after execution
`timescale 1ns/1ps
`default_nettype none
module fpp_pipe (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] osc_sel_i,
  input wire logic [15:0] pm_data_i,
  output var fpp_pkg::fpp_pm_req_s pm_req_o,
  output var fpp_pkg::fpp_dm_wr_s dm_wr_o,
  output logic [3:0] phase_o,
  output logic [7:0] acc_o,
  output logic [1:0] osc_src_o,
  output logic retire_o,
  output logic dummy_o,
  output logic call_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  fpp_pkg::fpp_phase_e phase; // current phase
  fpp_pkg::fpp_phase_e next_phase; // following phase
  logic [12:0] pc; // fetch address
  logic [15:0] fetch_q; // prefetched word
  logic fetch_v; // prefetch holds a word
  logic [15:0] exec_q; // word being executed
  logic exec_v; // exec word is real, not dummy
  logic flush_q; // discard prefetch at next fetch
  logic ext_wait; // extended op in its second cycle
  logic [7:0] acc; // accumulator
  logic [7:0] index; // indirect address register
  logic [1:0] osc_meta; // selector sync stage one
  logic [1:0] osc_sync; // selector sync stage two
  logic retire_q; // retire pulse
  logic dummy_q; // dummy cycle pulse
  logic call_q; // call pulse

  // ---------------------------------------------------------------
  // decode of the executing word
  // ---------------------------------------------------------------
  function automatic fpp_pkg::fpp_class_e op_class(input logic [15:0] w);
    op_class = fpp_pkg::fpp_class_e'(
      w[fpp_pkg::F_CLASS_HI:fpp_pkg::F_CLASS_LO]);
  endfunction : op_class

  wire fpp_pkg::fpp_class_e cls = op_class(exec_q);
  wire at_fetch = (phase == fpp_pkg::PH_FETCH);
  wire at_retire = (phase == fpp_pkg::PH_RETIRE);
  wire is_ext = exec_v && (cls == fpp_pkg::CL_EXT);
  wire stall = is_ext && !ext_wait; // first half of extended op
  wire do_exec = at_retire && exec_v && !stall;
  wire is_branch = do_exec &&
    ((cls == fpp_pkg::CL_JUMP) || (cls == fpp_pkg::CL_CALL));
  wire is_call = do_exec && (cls == fpp_pkg::CL_CALL);
  wire is_skip = cls == fpp_pkg::CL_SKIPDZ;
  wire is_aluop = (cls == fpp_pkg::CL_ALU) || (cls == fpp_pkg::CL_EXT);
  wire [7:0] imm = exec_q[7:0];
  // direct address from the word, or indirect through index
  wire [7:0] wr_addr = exec_q[fpp_pkg::F_INDIRECT] ? index : imm;
  wire dm_write = do_exec && (cls == fpp_pkg::CL_STORE);
  wire pcl_hit = dm_write && (wr_addr == fpp_pkg::ADDR_PCL);
  wire idx_hit = dm_write && (wr_addr == fpp_pkg::ADDR_INDEX);

  // ---------------------------------------------------------------
  // alu hookup: acc is always operand a
  // ---------------------------------------------------------------
  wire fpp_pkg::fpp_alu_e alu_sel = is_skip ? fpp_pkg::ALU_DEC :
    fpp_pkg::fpp_alu_e'(exec_q[fpp_pkg::F_ALU_HI:fpp_pkg::F_ALU_LO]);
  logic [7:0] alu_y; // alu result
  logic alu_zero; // alu result is zero

  fpp_alu u_alu (
    .a_i(acc),
    .b_i(imm),
    .op_i(alu_sel),
    .y_o(alu_y),
    .zero_o(alu_zero)
  );

  wire skip_hit = do_exec && is_skip && alu_zero;
  wire flush_now = is_branch || skip_hit || pcl_hit;
  // target, in-page short jump, or plain increment
  wire [12:0] pc_plus = 13'(pc + 13'h0001);
  wire [12:0] next_pc = is_branch ? exec_q[12:0] :
    pcl_hit ? {pc[12:8], acc} : pc_plus;

  // ---------------------------------------------------------------
  // phase generator
  // ---------------------------------------------------------------
  // fixed order fetch, decode, operate, retire
  always_comb begin
    case (phase)
      fpp_pkg::PH_FETCH: next_phase = fpp_pkg::PH_DECODE;
      fpp_pkg::PH_DECODE: next_phase = fpp_pkg::PH_OPERATE;
      fpp_pkg::PH_OPERATE: next_phase = fpp_pkg::PH_RETIRE;
      fpp_pkg::PH_RETIRE: next_phase = fpp_pkg::PH_FETCH;
      default: next_phase = fpp_pkg::PH_FETCH;
    endcase
  end

  // reset restarts at fetch
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      phase <= fpp_pkg::PH_FETCH;
    end else begin
      phase <= next_phase; // four phases make one cycle
    end
  end

  // one-hot, so no two phases are ever active together
  generate
    for (genvar g = 0; g < 4; g++) begin : g_phase
      assign phase_o[g] = (phase == fpp_pkg::fpp_phase_e'(g));
    end
  endgenerate

  // ---------------------------------------------------------------
  // program counter
  // ---------------------------------------------------------------
  // updated at the end of retire, so it is new at phase one
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pc <= fpp_pkg::PC_RESET; // start from address zero
    end else if (at_retire && !stall) begin
      pc <= next_pc; // branch lands a cycle late
    end
  end

  // ---------------------------------------------------------------
  // fetch and execute registers
  // ---------------------------------------------------------------
  // shift at end of fetch: new word in, older word to execute
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      fetch_q <= 16'h0000;
      fetch_v <= 1'b0; // no stale prefetch
      exec_q <= 16'h0000;
      exec_v <= 1'b0;
    end else if (at_fetch && !ext_wait) begin
      fetch_q <= pm_data_i; // fetch during phase one
      fetch_v <= 1'b1;
      exec_q <= fetch_q;
      exec_v <= fetch_v && !flush_q; // discarded word runs as dummy
    end
  end

  // flush request lives from retire to the next fetch
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      flush_q <= 1'b0;
    end else if (at_retire) begin
      flush_q <= flush_now; // pcl write also refetches
    end else if (at_fetch) begin
      flush_q <= 1'b0;
    end
  end

  // extended op holds the pipe for one more cycle
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ext_wait <= 1'b0;
    end else if (at_retire) begin
      ext_wait <= stall;
    end
  end

  // ---------------------------------------------------------------
  // accumulator and mapped index register
  // ---------------------------------------------------------------
  // results return to acc in the last execute phase
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      acc <= fpp_pkg::ACC_RESET;
    end else if (do_exec && (is_aluop || is_skip)) begin
      acc <= alu_y;
    end
  end

  // index register reached at its data address
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      index <= fpp_pkg::IDX_RESET;
    end else if (idx_hit) begin
      index <= acc;
    end
  end

  // ---------------------------------------------------------------
  // oscillator selector sync
  // ---------------------------------------------------------------
  // reports which of the four sources feeds sys_clk
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      osc_meta <= fpp_pkg::OSC_HIGH_SPEED_CRYSTAL;
      osc_sync <= fpp_pkg::OSC_HIGH_SPEED_CRYSTAL;
    end else begin
      osc_meta <= osc_sel_i;
      osc_sync <= osc_meta;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      dm_wr_o <= '0;
      retire_q <= 1'b0;
      dummy_q <= 1'b0;
      call_q <= 1'b0;
      osc_src_o <= fpp_pkg::OSC_HIGH_SPEED_CRYSTAL;
    end else begin
      dm_wr_o.wr <= dm_write;
      dm_wr_o.addr <= wr_addr;
      dm_wr_o.data <= acc;
      retire_q <= do_exec;
      dummy_q <= at_retire && !exec_v;
      call_q <= is_call;
      osc_src_o <= osc_sync;
    end
  end

  // fetch strobe only in phase one, not in the extended hold
  assign pm_req_o.rd = at_fetch && !ext_wait;
  assign pm_req_o.addr = pc;
  assign acc_o = acc;
  assign retire_o = retire_q;
  assign dummy_o = dummy_q;
  assign call_o = call_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_phase_walk;
    phase == fpp_pkg::PH_DECODE ##1 phase == fpp_pkg::PH_OPERATE
      ##1 phase == fpp_pkg::PH_RETIRE ##1 phase == fpp_pkg::PH_FETCH;
  endsequence

  sequence s_dummy_next;
    ##3 (at_retire && !exec_v);
  endsequence

  property p_phase_order;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      at_fetch |=> s_phase_walk;
  endproperty
  a_phase_order: assert property (p_phase_order)
    else $error("phase order broken");

  property p_phase_onehot;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      $onehot(phase_o) && phase_o[phase];
  endproperty
  a_phase_onehot: assert property (p_phase_onehot)
    else $error("phase outputs overlap");

  property p_pc_inc;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (at_retire && !stall && !flush_now) |=>
        (pc == 13'($past(pc) + 13'h0001)) && at_fetch;
  endproperty
  a_pc_inc: assert property (p_pc_inc)
    else $error("pc not incremented at fetch start");

  property p_exec_late;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      retire_o |-> $past(phase) == fpp_pkg::PH_RETIRE;
  endproperty
  a_exec_late: assert property (p_exec_late)
    else $error("execution outside execute phases");

  property p_overlap;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (do_exec && !flush_now && fetch_v && !ext_wait) |->
        ##4 (at_retire && exec_v);
  endproperty
  a_overlap: assert property (p_overlap)
    else $error("sequential word did not follow");

  property p_ext_two;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (at_retire && stall) |-> !retire_o ##4 (do_exec && ext_wait);
  endproperty
  a_ext_two: assert property (p_ext_two)
    else $error("extended op not two cycles");

  property p_branch;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      is_branch |=> (pc == $past(exec_q[12:0])) ##0 s_dummy_next;
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch target or dummy cycle wrong");

  property p_skip;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      skip_hit |=> s_dummy_next;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skipped word not discarded");

  property p_pcl;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      pcl_hit |=> (pc[7:0] == $past(acc)) &&
        (pc[12:8] == $past(pc[12:8])) ##0 s_dummy_next;
  endproperty
  a_pcl: assert property (p_pcl)
    else $error("pc low write not an in-page jump");

  property p_reset;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      $rose(resetn_i) |-> (pm_req_o.addr == fpp_pkg::PC_RESET) &&
        at_fetch && !exec_v && !fetch_v;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not restart pipeline");

  property p_first_fetch;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      $rose(resetn_i) |-> pm_req_o.rd ##4 (pm_req_o.addr == 13'h0001);
  endproperty
  a_first_fetch: assert property (p_first_fetch)
    else $error("fetch did not start at zero");

  property p_acc_path;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (do_exec && is_aluop) |=> acc_o == $past(alu_y);
  endproperty
  a_acc_path: assert property (p_acc_path)
    else $error("alu result not in accumulator");

endmodule : fpp_pipe
`default_nettype wire

// file: core/fpp_pkg.sv
// four-phase fetch/execute pipeline: shared constants, types, layouts
// assumes one system clock (already taken from the selected oscillator)
// and a synchronous active-low reset
// Notes on behaviour
// - system clock from one of four oscillators
// - four non-overlapping phases in fixed order
// - one pass of four phases is one cycle
// - pc increments and fetch starts in phase one
// - decode and execute in phases two to four
// - fetch overlaps execute, one retire per cycle
// - standard one cycle, extended two cycles
// - branches take two cycles: address, then branch
// - one 8-bit alu does all operations
// - operands and results pass accumulator and alu
// - control registers mapped, direct and indirect access
// - taken skip discards prefetch, inserts dummy cycle
// - pc low byte write: in-page jump, dummy
// - reset loads pc with zero and runs
package fpp_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int PC_W = 13; // program counter width
  localparam int IW_W = 16; // instruction word width
  localparam int DW_W = 8; // alu and data width

  // ---------------------------------------------------------------
  // reset values and mapped register addresses
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000; // reset vector
  localparam logic [DW_W-1:0] ACC_RESET = 8'h00; // accumulator at reset
  localparam logic [DW_W-1:0] IDX_RESET = 8'h00; // index at reset
  localparam logic [DW_W-1:0] ADDR_INDEX = 8'h04; // index register
  localparam logic [DW_W-1:0] ADDR_PCL = 8'h06; // pc low byte register

  // ---------------------------------------------------------------
  // instruction field positions
  // ---------------------------------------------------------------
  localparam int F_CLASS_HI = 15; // class field top bit
  localparam int F_CLASS_LO = 13; // class field low bit
  localparam int F_ALU_HI = 12; // alu op top bit
  localparam int F_ALU_LO = 10; // alu op low bit
  localparam int F_INDIRECT = 8; // indirect addressing bit

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_FETCH = 2'h0, // fetch_phase
    PH_DECODE = 2'h1, // decode_execute_phases, first
    PH_OPERATE = 2'h2, // decode_execute_phases, second
    PH_RETIRE = 2'h3 // decode_execute_phases, last
  } fpp_phase_e;

  typedef enum logic [1:0] {
    OSC_HIGH_SPEED_CRYSTAL = 2'h0, // high_speed_crystal_osc
    OSC_LOW_SPEED_CRYSTAL = 2'h1, // low_speed_crystal_osc
    OSC_HIGH_SPEED_INT_RC = 2'h2, // high_speed_internal_rc_osc
    OSC_LOW_SPEED_INT_RC = 2'h3 // low_speed_internal_rc_osc
  } fpp_osc_e;

  typedef enum logic [2:0] {
    CL_ALU = 3'h0, // acc = acc op immediate
    CL_EXT = 3'h1, // extended alu op, two cycles
    CL_JUMP = 3'h2, // jump to target
    CL_CALL = 3'h3, // call to target
    CL_SKIPDZ = 3'h4, // decrement acc, skip if zero
    CL_STORE = 3'h5, // store acc to data address
    CL_NOP = 3'h6, // no operation
    CL_NOP2 = 3'h7 // no operation
  } fpp_class_e;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_AND = 3'h2,
    ALU_OR = 3'h3,
    ALU_XOR = 3'h4,
    ALU_ROL = 3'h5,
    ALU_INC = 3'h6,
    ALU_DEC = 3'h7
  } fpp_alu_e;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rd; // fetch strobe
    logic [PC_W-1:0] addr; // fetch address
  } fpp_pm_req_s;

  typedef struct packed {
    logic wr; // write strobe
    logic [DW_W-1:0] addr; // data address
    logic [DW_W-1:0] data; // write data
  } fpp_dm_wr_s;

endpackage : fpp_pkg

// file: core/fpp_alu.sv
// single 8-bit alu for the four-phase pipeline
// assumes operands come from the accumulator and the instruction word
`timescale 1ns/1ps
`default_nettype none
module fpp_alu (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire fpp_pkg::fpp_alu_e op_i,
  output logic [7:0] y_o,
  output logic zero_o
);

  // ---------------------------------------------------------------
  // operation select
  // ---------------------------------------------------------------
  // arithmetic, logic, rotate, inc/dec share this one unit
  always_comb begin
    case (op_i)
      fpp_pkg::ALU_ADD: y_o = a_i + b_i;
      fpp_pkg::ALU_SUB: y_o = a_i - b_i;
      fpp_pkg::ALU_AND: y_o = a_i & b_i;
      fpp_pkg::ALU_OR: y_o = a_i | b_i;
      fpp_pkg::ALU_XOR: y_o = a_i ^ b_i;
      fpp_pkg::ALU_ROL: y_o = {a_i[6:0], a_i[7]};
      fpp_pkg::ALU_INC: y_o = a_i + 8'h01;
      fpp_pkg::ALU_DEC: y_o = a_i - 8'h01;
      default: y_o = a_i;
    endcase
  end

  // zero result drives the skip decision
  assign zero_o = (y_o == 8'h00);

endmodule : fpp_alu
`default_nettype wire

// file: sim/fpp_pmem_model.sv
// program memory partner for the four-phase pipeline
// assumes the pipeline's fetch strobe and address, one system clock
`timescale 1ns/1ps
`default_nettype none
module fpp_pmem_model (
  input wire logic sys_clk_i,
  input wire fpp_pkg::fpp_pm_req_s req_i,
  output logic [15:0] data_o
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0] mem [0:255]; // word image, filled by the bench
  logic [15:0] last = 16'h0000; // last word handed out

  // read in the fetch cycle; otherwise show the inverse of the last word
  // so that a stray sample never sees a stale but plausible word
  assign data_o = req_i.rd ? mem[req_i.addr[7:0]] : ~last;

  // remember the word just handed out
  always_ff @(posedge sys_clk_i) begin
    if (req_i.rd) begin
      last <= data_o;
    end
  end
endmodule : fpp_pmem_model
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the four-phase fetch/execute pipeline
// assumes fpp_pipe and the program memory partner model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0; // system clock, 8 ns
  logic resetn = 1'b0; // synchronous reset, active low
  logic [1:0] osc_sel = 2'h0; // oscillator source pins
  logic [15:0] pm_data; // word from the partner
  fpp_pkg::fpp_pm_req_s pm_req; // fetch request
  fpp_pkg::fpp_dm_wr_s dm_wr; // data write
  logic [3:0] phase_o;
  logic [7:0] acc_o;
  logic [1:0] osc_src_o;
  logic retire_o;
  logic dummy_o;
  logic call_o;
  logic [3:0] ph_exp = 4'h1; // expected phase this cycle
  logic [9:0] ev_q [$]; // notes: dummy, call, acc
  logic [15:0] dm_q [$]; // notes: address, data
  logic [31:0] seed = 32'h6f2b78f2; // xorshift state
  logic [7:0] pa; // program build address
  logic [7:0] acc_ref; // accumulator model
  int bad_count = 0;
  int checked = 0;
  localparam logic [15:0] POISON = 16'h105a; // xor that must never run

  always #4 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // design and partner
  // ---------------------------------------------------------------
  fpp_pipe dut (.sys_clk_i(sys_clk), .resetn_i(resetn),
    .osc_sel_i(osc_sel), .pm_data_i(pm_data), .pm_req_o(pm_req),
    .dm_wr_o(dm_wr), .phase_o(phase_o), .acc_o(acc_o),
    .osc_src_o(osc_src_o), .retire_o(retire_o), .dummy_o(dummy_o),
    .call_o(call_o));
  fpp_pmem_model pm (.sys_clk_i(sys_clk), .req_i(pm_req),
    .data_o(pm_data));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // compare and count
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // counts, verdict, end of run
  task automatic print_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // next random byte from the xorshift state
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd8

  // accumulator reference for one alu op
  function automatic logic [7:0] alu_ref(input logic [2:0] op,
                                         input logic [7:0] a,
                                         input logic [7:0] b);
    case (op)
      3'h0: return a + b;
      3'h1: return a - b;
      3'h2: return a & b;
      3'h3: return a | b;
      3'h4: return a ^ b;
      3'h5: return {a[6:0], a[7]};
      3'h6: return a + 8'h01;
      default: return a - 8'h01;
    endcase
  endfunction : alu_ref

  // place a word and step the build address
  task automatic put(input logic [15:0] w);
    pm.mem[pa] = w;
    pa = pa + 8'h01;
  endtask : put

  // expect one retire (d=0) or dummy (d=1) slot
  task automatic note(input logic d, input logic c);
    ev_q.push_back({d, c, acc_ref});
  endtask : note

  // ---------------------------------------------------------------
  // program image and its expected results
  // ---------------------------------------------------------------
  task automatic build();
    logic [7:0] imm;
    for (int i = 0; i < 256; i++) pm.mem[i] = 16'hc000;
    pa = 8'h00;
    acc_ref = 8'h00;
    ev_q.delete();
    dm_q.delete();
    // first retire slot after reset holds nothing yet
    note(1'b1, 1'b0);
    // every alu code with a random operand
    for (int k = 0; k < 8; k++) begin
      imm = rnd8();
      put({3'h0, k[2:0], 2'h0, imm});
      acc_ref = alu_ref(k[2:0], acc_ref, imm);
      note(1'b0, 1'b0);
    end
    put(16'ha020);
    note(1'b0, 1'b0);
    dm_q.push_back({8'h20, acc_ref});
    // index loaded through its mapped address, then an indirect store
    put(16'h0800);
    acc_ref = 8'h00;
    note(1'b0, 1'b0);
    put(16'h0021);
    acc_ref = 8'h21;
    note(1'b0, 1'b0);
    put(16'ha004);
    note(1'b0, 1'b0);
    dm_q.push_back({8'h04, 8'h21});
    put(16'ha100);
    note(1'b0, 1'b0);
    dm_q.push_back({8'h21, 8'h21});
    // jump, then call, each with the prefetched word discarded
    put(16'h4030);
    put(POISON);
    note(1'b0, 1'b0);
    note(1'b1, 1'b0);
    pa = 8'h30;
    put(16'h6038);
    put(POISON);
    note(1'b0, 1'b1);
    note(1'b1, 1'b0);
    // dec-skip reaching zero
    pa = 8'h38;
    put(16'h0800);
    acc_ref = 8'h00;
    note(1'b0, 1'b0);
    put(16'h0001);
    acc_ref = 8'h01;
    note(1'b0, 1'b0);
    put(16'h8000);
    acc_ref = 8'h00;
    note(1'b0, 1'b0);
    put(POISON);
    note(1'b1, 1'b0);
    // extended op, then a pc low byte write to 0x50
    imm = rnd8();
    put({8'h20, imm});
    acc_ref = imm;
    note(1'b0, 1'b0);
    put(16'h0800);
    acc_ref = 8'h00;
    note(1'b0, 1'b0);
    put(16'h0050);
    acc_ref = 8'h50;
    note(1'b0, 1'b0);
    put(16'ha006);
    dm_q.push_back({8'h06, 8'h50});
    put(POISON);
    note(1'b0, 1'b0);
    note(1'b1, 1'b0);
    pa = 8'h50;
    put(16'h4050);
  endtask : build

  // ---------------------------------------------------------------
  // one run from reset; full=0 cuts it short with the next reset
  // ---------------------------------------------------------------
  task automatic run(input int hold, input int cut, input bit full);
    int n;
    resetn = 1'b0;
    build();
    repeat (hold) @(negedge sys_clk);
    resetn = 1'b1;
    #1;
    cmp(17'(phase_o), 17'h1, "phase after reset");
    cmp(17'(pm_req.addr), 17'h0, "reset address");
    cmp(17'(pm_req.rd), 17'h1, "first fetch");
    for (int c = 0; c < 4; c++) begin
      @(negedge sys_clk);
      osc_sel = c[1:0];
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      cmp(17'(osc_src_o), 17'(c[1:0]), "osc source");
    end
    n = 0;
    while ((ev_q.size() != 0 || dm_q.size() != 0) && n < cut) begin
      @(negedge sys_clk);
      n++;
    end
    if (full && n >= cut) begin
      bad_count++;
      $display("[ERR] %0t results missing", $time);
      print_verdict();
    end
  endtask : run

  // ---------------------------------------------------------------
  // monitor: phases, fetch timing, notes taken in order
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    ph_exp <= resetn ? {ph_exp[2:0], ph_exp[3]} : 4'h1;
  end

  // compare settled outputs at the falling edge
  always @(negedge sys_clk) begin
    if (resetn === 1'b1) begin
      cmp(17'(phase_o), 17'(ph_exp), "phase");
      if (pm_req.rd === 1'b1) begin
        cmp(17'(phase_o), 17'h1, "fetch phase");
      end
      if (dm_wr.wr === 1'b1 && dm_q.size() != 0) begin
        cmp(17'({dm_wr.addr, dm_wr.data}), 17'(dm_q.pop_front()),
            "data write");
      end else if (dm_wr.wr !== 1'b0) begin
        // a write with no note behind it is a mismatch too
        bad_count++;
        $display("[ERR] %0t unexpected data write", $time);
      end
      if ((retire_o | dummy_o) === 1'b1 && ev_q.size() != 0) begin
        cmp(17'({dummy_o, call_o, acc_o}), 17'(ev_q.pop_front()),
            "retire slot");
      end
    end
  end

  // ---------------------------------------------------------------
  // main sequence: full run, reset mid-run, full run again
  // ---------------------------------------------------------------
  initial begin
    run(8, 400, 1'b1);
    run(2, 40, 1'b0);
    run(2, 400, 1'b1);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
